/* common/host_port_pkg.sv */
// Shared constants and types of the parallel host port.
package host_port_pkg;

    // ------------------------------------------------------------
    // Clock and character timing.
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHAR_DIV = 10;
    localparam int TX_CLEAR_MIN = 8;
    localparam int SELFTEST_LEN = 511;

    // ------------------------------------------------------------
    // Widths and depths.
    // ------------------------------------------------------------
    localparam int CHAR_W = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int LFSR_W = 9;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 9'h1ff;
    localparam int LFSR_TAP = 4;

    // ------------------------------------------------------------
    // Special codes and policies.
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_IRQ_SET = 8'h1c;
    localparam logic [7:0] CODE_IRQ_CLR = 8'h7c;
    localparam logic [1:0] DISCARD_KEEP = 2'h0;

    typedef logic [CHAR_W-1:0] char_t;

    typedef struct packed {
        char_t chr;
        logic special;
        logic violation;
        logic cell_start;
    } rx_entry_t;

    typedef struct packed {
        logic fifo_bypass_n;
        logic codec_bypass_n;
        logic char_width_sel;
        logic [1:0] discard_policy;
    } port_cfg_t;

    typedef enum logic {
        TX_HOST = 1'b0,
        TX_SELFTEST = 1'b1
    } tx_mode_t;

endpackage

/* logic/host_port.sv */
// Host port status, transmit self test and receive bus multiplexer.
//
// Contract
// [R1] Bypassed FIFO: empty flag means ready.
// [R2] Self test: empty flag pulses at sequence end.
// [R3] Clear held eight cycles starts FIFO clear.
// [R4] Clear input ignored while FIFO bypassed.
// [R5] Self test sends repeating 511-character sequence.
// [R6] Self test off resumes host data.
// [R7] Transmit FIFO reads stop during self test.
// [R8] Self-test enable synchronised before use.
// [R9] Receive bus updates only when addressed, enabled.
// [R10] Codec bypass: low bits carry raw character.
// [R11] Set code drives remote interrupt high.
// [R12] Clear code drives remote interrupt low.
// [R13] Interrupt codes dropped unless discard policy 0.
// [R14] FIFO bypassed, decoded: interrupt bit unused.
// [R15] Codec bypass: bit 8 is raw bit 8.
// [R16] Decoded 10-bit: bit 9 is data MSB.
// [R17] Host ignores bit 9 in decoded 8-bit.
// [R18] Codec bypass: bit 9 is raw bit 9.
// [R19] FIFO decoded: violation bit encodes specials.
// [R20] No FIFO, decoded: violation flags bad code.
// [R21] Raw 10-bit width: bit 10 is raw bit 10.
// [R22] Raw 8-bit width: bit 10 driven low.
// [R23] FIFO read each edge while enabled, else undriven.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Synchronous FIFO with valid and ready on both sides.
// ----------------------------------------------------------------
module fifo_buf #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic flush_i,
    // Write side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Read side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo_buf depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = count != (AW+1)'(DEPTH);
    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// Host port top.
// ----------------------------------------------------------------
module host_port #(
    parameter int DEPTH = host_port_pkg::FIFO_DEPTH,
    parameter int DIV = host_port_pkg::CHAR_DIV
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic nrst_i,
    // Configuration.
    input wire host_port_pkg::port_cfg_t cfg_i,
    // Transmit host side.
    input wire host_port_pkg::char_t tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_fifo_clear_n_i,
    input wire logic tx_selftest_en_n_i,
    output logic tx_empty_flag_o,
    // Transmit line side.
    output host_port_pkg::char_t tx_char_o,
    output logic tx_char_strobe_o,
    // Receive line side.
    input wire host_port_pkg::rx_entry_t rx_line_i,
    input wire logic rx_line_valid_i,
    output logic rx_line_ready_o,
    // Receive host side.
    input wire logic address_match_n_i,
    input wire logic rx_enable_n_i,
    output host_port_pkg::char_t rx_bus_o,
    output logic rx_special_flag_o,
    output logic rx_bus_oe_o,
    output logic rx_remote_irq_o
);
    import host_port_pkg::*;

    localparam int LW = $clog2(DEPTH) + 1;
    localparam logic [LW-1:0] ROOM = LW'(DEPTH - 1);

    if (DIV < 2 || DIV > 256 || DEPTH < 4) begin : g_bad_param
        $error("host_port needs DIV in 2..256 and DEPTH >= 4");
    end

    // ------------------------------------------------------------
    // Character rate divider.
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic char_tick;

    always_ff @(posedge clk_i) begin
        if (!nrst_i || div_cnt == 8'(DIV - 1)) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign char_tick = div_cnt == 8'(DIV - 1);

    // ------------------------------------------------------------
    // Self-test enable synchroniser and mode.
    // ------------------------------------------------------------
    logic st_meta_n;
    logic st_sync_n;
    tx_mode_t tx_mode;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_meta_n <= 1'b1;
            st_sync_n <= 1'b1;
        end else begin
            st_meta_n <= tx_selftest_en_n_i; // R8
            st_sync_n <= st_meta_n; // R8
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_mode <= TX_HOST;
        end else if (char_tick) begin
            tx_mode <= st_sync_n ? TX_HOST : TX_SELFTEST; // R5 R6
        end
    end

    // ------------------------------------------------------------
    // Transmit FIFO clear.
    // ------------------------------------------------------------
    logic [3:0] clr_cnt;
    logic tx_flush;

    always_ff @(posedge clk_i) begin
        if (!nrst_i || tx_fifo_clear_n_i) begin
            clr_cnt <= 4'h0;
        end else if (clr_cnt != 4'(TX_CLEAR_MIN)) begin
            clr_cnt <= clr_cnt + 4'h1;
        end
    end
    assign tx_flush = !tx_fifo_clear_n_i && cfg_i.fifo_bypass_n
        && clr_cnt == 4'(TX_CLEAR_MIN - 1); // R3 R4

    // ------------------------------------------------------------
    // Transmit data path.
    // ------------------------------------------------------------
    logic tx_write;
    logic tx_pop;
    logic tx_fifo_valid;
    char_t tx_fifo_data;
    logic [LW-1:0] tx_level;
    logic byp_full;
    logic next_byp_full;
    char_t byp_data;
    logic byp_send;

    assign tx_write = tx_valid_i && tx_ready_o;
    assign tx_pop = cfg_i.fifo_bypass_n && char_tick
        && tx_mode == TX_HOST && tx_fifo_valid; // R7
    assign byp_send = !cfg_i.fifo_bypass_n && char_tick
        && tx_mode == TX_HOST && byp_full;

    fifo_buf #(.WIDTH(CHAR_W), .DEPTH(DEPTH)) u_tx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .flush_i(tx_flush),
        .in_valid_i(tx_write && cfg_i.fifo_bypass_n),
        .in_ready_o(),
        .in_data_i(tx_data_i),
        .out_valid_o(tx_fifo_valid),
        .out_ready_i(tx_pop),
        .out_data_o(tx_fifo_data),
        .level_o(tx_level)
    );

    always_comb begin
        next_byp_full = byp_full;
        if (cfg_i.fifo_bypass_n || byp_send) begin
            next_byp_full = 1'b0;
        end
        if (tx_write && !cfg_i.fifo_bypass_n) begin
            next_byp_full = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            byp_full <= 1'b0;
            byp_data <= '0;
        end else begin
            byp_full <= next_byp_full;
            if (tx_write && !cfg_i.fifo_bypass_n) begin
                byp_data <= tx_data_i;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_ready_o <= 1'b0;
        end else if (cfg_i.fifo_bypass_n) begin
            tx_ready_o <= tx_level + LW'(tx_write) < ROOM;
        end else begin
            tx_ready_o <= !next_byp_full;
        end
    end

    // ------------------------------------------------------------
    // Self-test sequence generator.
    // ------------------------------------------------------------
    logic [LFSR_W-1:0] lfsr;
    logic [8:0] st_cnt;
    logic st_end;

    assign st_end = tx_mode == TX_SELFTEST && char_tick
        && st_cnt == 9'(SELFTEST_LEN - 1);

    always_ff @(posedge clk_i) begin
        if (!nrst_i || tx_mode == TX_HOST) begin
            lfsr <= LFSR_SEED;
            st_cnt <= 9'h000;
        end else if (char_tick) begin
            lfsr <= {lfsr[LFSR_W-2:0], lfsr[LFSR_W-1] ^ lfsr[LFSR_TAP]};
            st_cnt <= st_end ? 9'h000 : st_cnt + 9'h001; // R5
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_char_o <= '0;
            tx_char_strobe_o <= 1'b0;
        end else begin
            tx_char_strobe_o <= 1'b0;
            if (tx_mode == TX_SELFTEST && char_tick) begin
                tx_char_o <= CHAR_W'(lfsr); // R5
                tx_char_strobe_o <= 1'b1;
            end else if (tx_pop) begin
                tx_char_o <= tx_fifo_data; // R6
                tx_char_strobe_o <= 1'b1;
            end else if (byp_send) begin
                tx_char_o <= byp_data; // R6
                tx_char_strobe_o <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_empty_flag_o <= 1'b0;
        end else if (tx_mode == TX_SELFTEST) begin
            tx_empty_flag_o <= st_end; // R2
        end else if (!cfg_i.fifo_bypass_n) begin
            tx_empty_flag_o <= !next_byp_full; // R1
        end else begin
            tx_empty_flag_o <= tx_level == LW'(0) && !tx_write;
        end
    end

    // ------------------------------------------------------------
    // Receive interrupt code extraction.
    // ------------------------------------------------------------
    logic rx_fifo_mode;
    logic rx_take;
    logic code_set;
    logic code_clr;
    logic rx_push;
    logic [LW-1:0] rx_level;
    logic rx_fifo_valid;
    logic rx_pop;
    logic rx_en;
    rx_entry_t rx_fifo_data;

    assign rx_fifo_mode = cfg_i.fifo_bypass_n && cfg_i.codec_bypass_n;
    assign rx_take = rx_line_valid_i && rx_line_ready_o;
    assign code_set = rx_fifo_mode && rx_line_i.special
        && rx_line_i.chr[7:0] == CODE_IRQ_SET;
    assign code_clr = rx_fifo_mode && rx_line_i.special
        && rx_line_i.chr[7:0] == CODE_IRQ_CLR;
    assign rx_push = rx_take && cfg_i.fifo_bypass_n && !((code_set
        || code_clr) && cfg_i.discard_policy != DISCARD_KEEP); // R13
    assign rx_en = !address_match_n_i && !rx_enable_n_i;
    assign rx_pop = rx_en && rx_fifo_valid && cfg_i.fifo_bypass_n; // R23

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_remote_irq_o <= 1'b0;
        end else if (rx_take && code_set) begin
            rx_remote_irq_o <= 1'b1; // R11
        end else if (rx_take && code_clr) begin
            rx_remote_irq_o <= 1'b0; // R12
        end
    end

    fifo_buf #(.WIDTH($bits(rx_entry_t)), .DEPTH(DEPTH)) u_rx_fifo (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .flush_i(1'b0),
        .in_valid_i(rx_push),
        .in_ready_o(),
        .in_data_i(rx_line_i),
        .out_valid_o(rx_fifo_valid),
        .out_ready_i(rx_pop),
        .out_data_o(rx_fifo_data),
        .level_o(rx_level)
    );

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_line_ready_o <= 1'b0;
        end else begin
            rx_line_ready_o <= !cfg_i.fifo_bypass_n
                || rx_level + LW'(rx_push) < ROOM;
        end
    end

    // ------------------------------------------------------------
    // Receive bus multiplexer.
    // ------------------------------------------------------------
    function automatic char_t map_bus(rx_entry_t e, logic irq);
        char_t b;
        b = '0; // R22
        if (!cfg_i.codec_bypass_n) begin
            b[9:0] = e.chr[9:0]; // R10 R15 R18
            if (!cfg_i.char_width_sel) begin
                b[11:10] = e.chr[11:10]; // R21
            end
        end else begin
            b[7:0] = e.chr[7:0];
            if (!cfg_i.char_width_sel) begin
                b[9] = e.chr[9]; // R16 R17
            end
            if (cfg_i.fifo_bypass_n) begin
                b[8] = irq;
                b[11] = e.cell_start;
            end else if (!cfg_i.char_width_sel) begin
                b[8] = e.chr[8]; // R14
            end
            b[10] = e.violation; // R19 R20
        end
        return b;
    endfunction

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rx_bus_o <= '0;
            rx_special_flag_o <= 1'b0;
            rx_bus_oe_o <= 1'b0;
        end else begin
            rx_bus_oe_o <= rx_en; // R23
            if (rx_pop) begin
                rx_bus_o <= map_bus(rx_fifo_data, rx_remote_irq_o); // R9
                rx_special_flag_o <= rx_fifo_data.special
                    && cfg_i.codec_bypass_n;
            end else if (rx_en && rx_take && !cfg_i.fifo_bypass_n) begin
                rx_bus_o <= map_bus(rx_line_i, 1'b0); // R9
                rx_special_flag_o <= rx_line_i.special
                    && cfg_i.codec_bypass_n;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    chk_bypass_empty: assert property ( // R1
        tx_mode == TX_HOST && $past(tx_mode) == TX_HOST && $past(nrst_i)
        && !$past(cfg_i.fifo_bypass_n) |-> tx_empty_flag_o == !byp_full)
        else $error("empty flag does not follow bypass holder");
    chk_selftest_pulse: assert property ( // R2
        tx_mode == TX_SELFTEST && tx_empty_flag_o |=> !tx_empty_flag_o)
        else $error("self test empty pulse longer than one cycle");
    chk_selftest_end: assert property ( // R5
        st_end |=> tx_empty_flag_o && tx_char_strobe_o)
        else $error("self test end not marked");
    chk_clear_hold: assert property ( // R3
        tx_flush |-> $past(!tx_fifo_clear_n_i, 7) && $past(nrst_i, 7))
        else $error("FIFO cleared before eight held cycles");
    chk_clear_bypass: assert property ( // R4
        !cfg_i.fifo_bypass_n |-> !tx_flush)
        else $error("FIFO cleared while bypassed");
    chk_selftest_noread: assert property ( // R7
        tx_mode == TX_SELFTEST |-> !tx_pop)
        else $error("transmit FIFO read during self test");
    chk_rx_hold: assert property ( // R9
        !rx_en |=> $stable(rx_bus_o))
        else $error("receive bus changed while not selected");
    chk_irq_set: assert property ( // R11
        rx_take && code_set |=> rx_remote_irq_o)
        else $error("remote interrupt not set");
    chk_irq_clr: assert property ( // R12
        rx_take && code_clr |=> !rx_remote_irq_o)
        else $error("remote interrupt not cleared");
    chk_code_drop: assert property ( // R13
        rx_take && (code_set || code_clr)
        && cfg_i.discard_policy != DISCARD_KEEP |-> !rx_push)
        else $error("interrupt code stored in receive FIFO");
    chk_raw8_low: assert property ( // R22
        rx_pop && !cfg_i.codec_bypass_n && cfg_i.char_width_sel
        |=> !rx_bus_o[10] && !rx_bus_o[11])
        else $error("raw 8-bit mode drives upper bits");
    chk_rx_oe: assert property ( // R23
        rx_en ##1 !rx_en |-> rx_bus_oe_o ##1 !rx_bus_oe_o)
        else $error("receive bus enable does not follow selection");

    cov_selftest_wrap: cover property (st_end);
    cov_irq_toggle: cover property (
        rx_take && code_set ##[1:50] rx_take && code_clr);
    cov_rx_full: cover property (!rx_line_ready_o && rx_fifo_valid);
    cov_tx_clear: cover property (tx_flush);
endmodule

/* tb/host_model.sv */
// Host-side partner driving receive selection and transmit FIFO clear.
`timescale 1ns/100ps
module host_model (
    // Clock.
    input wire logic clk_i,
    // Requests from the bench.
    input wire logic want_i,
    input wire logic clear_req_i,
    input wire logic wide_i,
    input wire host_port_pkg::char_t bus_i,
    // Host port pins.
    output logic address_match_n_o,
    output logic rx_enable_n_o,
    output logic tx_fifo_clear_n_o,
    output host_port_pkg::char_t word_o
);
    import host_port_pkg::*;
    logic [3:0] hold = 4'h0;
    // Selection asks for one entry on every edge while it is held.
    assign address_match_n_o = ~want_i;
    assign rx_enable_n_o = ~want_i;
    // Bit 9 carries nothing in decoded 8-bit width.
    assign word_o = wide_i ? bus_i : (bus_i & 12'hdff);
    // Clear is held low for the minimum count of edges.
    always_ff @(posedge clk_i) begin
        if (clear_req_i && hold == 4'h0) begin
            hold <= 4'(TX_CLEAR_MIN);
        end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
        end
    end
    assign tx_fifo_clear_n_o = (hold == 4'h0);
endmodule

/* tb/host_port_tb_top.sv */
// Self-checking bench of the host port against a queue model.
`timescale 1ns/100ps
module host_port_tb_top;
    import host_port_pkg::*;
    localparam int DIV_TB = 4;
    logic clk_i = 0, nrst_i = 0, tx_valid_i = 0, selt_n = 1;
    logic rx_line_valid_i = 0, want = 0, clr_req = 0, st_mode = 0;
    port_cfg_t cfg_i = '0;
    char_t tx_data_i = '0, tx_char_o, rx_bus_o, word;
    rx_entry_t rx_line_i = '0;
    logic tx_ready_o, clr_n, tx_empty_flag_o, tx_char_strobe_o, am_n, en_n;
    logic rx_line_ready_o, rx_special_flag_o, rx_bus_oe_o, rx_remote_irq_o;
    char_t txq[$];
    rx_entry_t rxq[$];
    int err_count = 0, checked = 0, seed = 32'h4b7a76c1;
    int npulse = 0, between = 0, host_seen = 0, w;
    logic irq_m = 0;

    host_port #(.DEPTH(FIFO_DEPTH), .DIV(DIV_TB)) host_port_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .cfg_i(cfg_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .tx_fifo_clear_n_i(clr_n),
        .tx_selftest_en_n_i(selt_n), .tx_empty_flag_o(tx_empty_flag_o),
        .tx_char_o(tx_char_o), .tx_char_strobe_o(tx_char_strobe_o),
        .rx_line_i(rx_line_i), .rx_line_valid_i(rx_line_valid_i),
        .rx_line_ready_o(rx_line_ready_o), .address_match_n_i(am_n),
        .rx_enable_n_i(en_n), .rx_bus_o(rx_bus_o),
        .rx_special_flag_o(rx_special_flag_o), .rx_bus_oe_o(rx_bus_oe_o),
        .rx_remote_irq_o(rx_remote_irq_o));
    host_model host_model_inst (
        .clk_i(clk_i), .want_i(want), .clear_req_i(clr_req),
        .wide_i(~(cfg_i.codec_bypass_n & cfg_i.char_width_sel)),
        .bus_i(rx_bus_o), .address_match_n_o(am_n), .rx_enable_n_o(en_n),
        .tx_fifo_clear_n_o(clr_n), .word_o(word));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Checking and closing.
    // ------------------------------------------------------------
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [11:0] exp,
                         input logic [11:0] got);
        checked++;
        if (exp !== got) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic rx_entry_t rnd_entry();
        rx_entry_t e;
        e = rx_entry_t'(15'($random(seed)));
        e.special = 1'b0;
        return e;
    endfunction

    function automatic char_t map(input rx_entry_t e);
        char_t b;
        b = e.chr;
        if (cfg_i.codec_bypass_n) begin
            b[8] = cfg_i.fifo_bypass_n ? irq_m : b[8] & !cfg_i.char_width_sel;
            b[10] = e.violation;
            b[11] = e.cell_start & cfg_i.fifo_bypass_n;
            if (cfg_i.char_width_sel) b[9] = 1'b0;
        end else if (cfg_i.char_width_sel) begin
            b[11:10] = 2'h0;
        end
        return b;
    endfunction

    // Transmit line monitor: host characters in order, self-test counts.
    always @(posedge clk_i) begin
        if (tx_char_strobe_o === 1'b1 && st_mode) begin
            between++;
            if (tx_char_o === 12'habc) begin
                check("host char in test", 12'h1, 12'(selt_n));
                host_seen++;
            end
            if (tx_empty_flag_o === 1'b1) begin
                if (npulse > 1)
                    check("test length", 12'(SELFTEST_LEN), 12'(between));
                npulse++;
                between = 0;
            end
        end else if (tx_char_strobe_o === 1'b1) begin
            if (txq.size() == 0) check("tx spurious", 12'h0, 12'h1);
            else check("tx char", txq.pop_front(), tx_char_o);
        end
        if (st_mode && npulse > 1 && selt_n === 1'b0 &&
            tx_empty_flag_o === 1'b1 && tx_char_strobe_o !== 1'b1)
            check("empty pulse", 12'h0, 12'h1);
    end

    // ------------------------------------------------------------
    // Drivers.
    // ------------------------------------------------------------
    task automatic restart(input port_cfg_t c);
        nrst_i = 0;
        cfg_i = c;
        txq.delete();
        rxq.delete();
        irq_m = 0;
        repeat (8) @(negedge clk_i);
        nrst_i = 1;
        repeat (2) @(negedge clk_i);
    endtask

    task automatic tx_write(input char_t d);
        int n;
        tx_data_i = d;
        tx_valid_i = 1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (tx_ready_o === 1'b1) break;
        end
        if (n == 200) begin
            check("tx ready wait", 12'h1, 12'h0);
            close_out();
        end
        txq.push_back(d);
        @(negedge clk_i);
    endtask

    task automatic rx_send(input rx_entry_t e);
        int n;
        rx_line_i = e;
        rx_line_valid_i = 1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_i);
            if (rx_line_ready_o === 1'b1) break;
        end
        if (n == 200) begin
            check("rx ready wait", 12'h1, 12'h0);
            close_out();
        end
        if (e.special && e.chr[7:0] == CODE_IRQ_SET) irq_m = 1;
        if (e.special && e.chr[7:0] == CODE_IRQ_CLR) irq_m = 0;
        if (!e.special || cfg_i.discard_policy == DISCARD_KEEP)
            rxq.push_back(e);
        @(negedge clk_i);
    endtask

    task automatic rx_fill();
        int n;
        for (n = 0; n < 40; n++) begin
            rx_line_i = rnd_entry();
            rx_line_valid_i = 1;
            @(posedge clk_i);
            if (rx_line_ready_o !== 1'b1) break;
            rxq.push_back(rx_line_i);
            @(negedge clk_i);
        end
        check("rx refused", 12'h1, 12'(n < 40));
        @(negedge clk_i);
        rx_line_valid_i = 0;
    endtask

    task automatic rx_read(input int n);
        rx_entry_t e;
        logic sp;
        @(negedge clk_i);
        want = 1;
        repeat (n) begin
            @(negedge clk_i);
            e = rxq.pop_front();
            sp = e.special & cfg_i.codec_bypass_n;
            check("rx bus", map(e), word);
            check("rx special", 12'(sp), 12'(rx_special_flag_o));
        end
        want = 0;
        @(negedge clk_i);
        check("bus released", 12'h0, 12'(rx_bus_oe_o));
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    initial begin
        @(negedge clk_i);
        restart(5'h19);
        check("bus idle", 12'h0, 12'(rx_bus_oe_o));
        repeat (6) tx_write(char_t'($random(seed)));
        tx_valid_i = 0;
        rx_send('{12'h01c, 1'b1, 1'b0, 1'b0});
        repeat (3) rx_send(rnd_entry());
        rx_line_valid_i = 0;
        rx_read(3);
        check("irq set", 12'h1, 12'(rx_remote_irq_o));
        rx_send('{12'h07c, 1'b1, 1'b0, 1'b0});
        rx_send(rnd_entry());
        rx_line_valid_i = 0;
        rx_read(1);
        check("irq clear", 12'h0, 12'(rx_remote_irq_o));
        repeat (12) tx_write(char_t'($random(seed)));
        tx_valid_i = 0;
        clr_req = 1;
        @(negedge clk_i);
        clr_req = 0;
        repeat (10) @(negedge clk_i);
        check("empty after clear", 12'h1, 12'(tx_empty_flag_o));
        repeat (2 * DIV_TB) @(negedge clk_i);
        txq.delete();
        repeat (2) tx_write(char_t'($random(seed)));
        tx_valid_i = 0;
        repeat (6 * DIV_TB) @(negedge clk_i);
        check("tx drained", 12'h0, 12'(txq.size()));
        restart(5'h1c);
        rx_send('{12'h01c, 1'b1, 1'b0, 1'b0});
        rx_line_valid_i = 0;
        rx_read(1);
        for (w = 0; w < 2; w++) begin
            restart(port_cfg_t'(5'h10 + 5'(4 * w)));
            rx_fill();
            rx_read(rxq.size());
        end
        restart(5'h08);
        check("bypass ready", 12'h1, 12'(tx_empty_flag_o));
        clr_req = 1;
        @(negedge clk_i);
        clr_req = 0;
        tx_write(char_t'($random(seed)));
        tx_valid_i = 0;
        check("bypass busy", 12'h0, 12'(tx_empty_flag_o));
        repeat (4 * DIV_TB) @(negedge clk_i);
        check("bypass sent", 12'h0, 12'(txq.size()));
        want = 1;
        rx_send('{12'h155, 1'b0, 1'b1, 1'b0});
        rx_line_valid_i = 0;
        check("violation bit", 12'h1, 12'(rx_bus_o[10]));
        check("bypass bus", map(rxq.pop_back()), rx_bus_o);
        want = 0;
        restart(5'h19);
        selt_n = 0;
        st_mode = 1;
        for (w = 0; w < 10000 && npulse < 3; w++) @(negedge clk_i);
        if (npulse < 3) begin
            check("test pulses", 12'h3, 12'(npulse));
            close_out();
        end
        tx_write(12'habc);
        tx_valid_i = 0;
        txq.delete();
        repeat (8 * DIV_TB) @(negedge clk_i);
        selt_n = 1;
        repeat (8 * DIV_TB) @(negedge clk_i);
        check("host resumed", 12'h1, 12'(host_seen));
        close_out();
    end
endmodule
